// ---- hdl/scss_pkg.sv ----
// Constants, field layouts and carrier types of the clock source selector
package scss_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SEL  = 8'h8f;
  localparam logic [7:0] ADDR_LF_CTRL  = 8'had;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'hb6;

  // ---------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CLK_SEL_RST   = 8'h00;
  localparam logic [7:0] LF_CTRL_RST   = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST  = 8'h00;
  localparam logic [7:0] CLK_SEL_WMASK = 8'h37;
  localparam logic [7:0] LF_CTRL_WMASK = 8'hbf;
  localparam logic [7:0] EXT_CTRL_WMASK = 8'h77;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LF_EN_BIT      = 7;
  localparam int LF_RDY_BIT     = 6;
  localparam int LF_TRIM_LSB    = 2;
  localparam int LF_DIV_LSB     = 0;
  localparam int SEL_ODIV_LSB   = 4;
  localparam int SEL_SRC_LSB    = 0;
  localparam int EXT_VALID_BIT  = 7;
  localparam int EXT_MODE_LSB   = 4;
  localparam int EXT_FCN_LSB    = 0;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_CODE_HF  = 3'h0;
  localparam logic [2:0] SRC_CODE_EXT = 3'h1;
  localparam logic [2:0] SRC_CODE_LF  = 3'h2;
  localparam logic [2:0] SRC_CODE_PLL = 3'h4;
  localparam logic [2:0] XMODE_CMOS     = 3'h2;
  localparam logic [2:0] XMODE_CMOS_DIV = 3'h3;
  localparam logic [1:0] XMODE_XTAL_HI  = 2'h3;
  localparam logic [1:0] XMODE_OFF_HI   = 2'h0;

  // Index of each asynchronous input in the synchroniser vector
  localparam int SY_HF   = 0;
  localparam int SY_LF   = 1;
  localparam int SY_EXT  = 2;
  localparam int SY_PLL  = 3;
  localparam int SY_LFOK = 4;
  localparam int SY_XOK  = 5;
  localparam int SY_LOCK = 6;
  localparam int SY_N    = 7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_HF, SRC_EXT, SRC_LF, SRC_PLL} scss_src_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } scss_sfr_req_s;

  typedef struct packed {
    logic        pulse;
    logic [15:0] value;
  } scss_cap_s;

endpackage

// ---- hdl/scss_div.sv ----
// Edge-counting clock divider by 1, 2, 4 or 8 for sampled clock levels
`timescale 1ns/1ps
`default_nettype none
module scss_div (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  // Sampled clock and log2 of the ratio
  input  wire logic       level_in,
  input  wire logic [1:0] shift_in,
  // Divided level
  output logic            level_out
);

  logic [3:0] cnt_r;
  logic       prev_r;
  logic       out_r;

  // Counter steps on every transition, so bit k runs at input/2^k
  wire        edge_w  = level_in ^ prev_r;
  wire  [3:0] cnt_nxt = edge_w ? 4'(cnt_r + 4'h1) : cnt_r;
  wire        out_nxt = cnt_nxt[shift_in];

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt_r  <= 4'h0;
      prev_r <= 1'b0;
      out_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      prev_r <= level_in;
      out_r  <= out_nxt;
    end
  end

  assign level_out = out_r;

endmodule
`default_nettype wire

// ---- hdl/scss_top.sv ----
// Clock source select, oscillator control registers and capture logic
`timescale 1ns/1ps
`default_nettype none
module scss_top (
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   srst_in,
  // Special-function register port
  input  wire scss_pkg::scss_sfr_req_s sfr_req_in,
  output logic [7:0]                  sfr_rdata_out,
  // Settings held in other registers of the device
  input  wire logic [1:0]             high_freq_divider_in,
  input  wire logic [3:0]             trim_cal_in,
  // Raw oscillator levels and analog status
  input  wire logic                   hf_osc_in,
  input  wire logic                   lf_osc_in,
  input  wire logic                   ext_osc_in,
  input  wire logic                   pll_clk_in,
  input  wire logic                   lf_settled_in,
  input  wire logic                   xtal_stable_in,
  input  wire logic                   pll_locked_in,
  // Timer capture
  input  wire logic                   t2_capture_mode_in,
  input  wire logic                   t3_capture_mode_in,
  input  wire logic [15:0]            t2_count_in,
  input  wire logic [15:0]            t3_count_in,
  output scss_pkg::scss_cap_s         t2_cap_out,
  output scss_pkg::scss_cap_s         t3_cap_out,
  // Oscillator controls
  output logic                        low_freq_osc_enable_out,
  output logic [3:0]                  low_freq_fine_tune_out,
  output logic [2:0]                  external_osc_mode_out,
  output logic [2:0]                  external_freq_control_out,
  output logic                        pll_lock_flag_out,
  // Clocks
  output logic                        system_clock_out,
  output logic                        clock_pin_out,
  output logic                        ext_timer_clock_out,
  output scss_pkg::scss_src_e         active_source_out,
  // Crystal pin takeover
  output logic                        crystal_pin_in_claim_out,
  output logic                        crystal_pin_out_claim_out
);
  import scss_pkg::*;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [SY_N-1:0] sync1_r;
  logic [SY_N-1:0] sync_r;
  wire  [SY_N-1:0] raw_w = {pll_locked_in, xtal_stable_in, lf_settled_in,
                            pll_clk_in, ext_osc_in, lf_osc_in, hf_osc_in};

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sync1_r <= '0;
      sync_r  <= '0;
    end else begin
      sync1_r <= raw_w;
      sync_r  <= sync1_r;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] clk_sel_r;
  logic [7:0] lf_ctrl_r;
  logic [7:0] ext_ctrl_r;

  wire wr_sel_w = sfr_req_in.wr && (sfr_req_in.addr == ADDR_CLK_SEL);
  wire wr_lf_w  = sfr_req_in.wr && (sfr_req_in.addr == ADDR_LF_CTRL);
  wire wr_ext_w = sfr_req_in.wr && (sfr_req_in.addr == ADDR_EXT_CTRL);
  // Trim is reloaded from the calibration fuses on every reset
  wire [7:0] lf_rst_w = LF_CTRL_RST |
                        8'({trim_cal_in, 2'b00});

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      clk_sel_r  <= CLK_SEL_RST;
      lf_ctrl_r  <= lf_rst_w;
      ext_ctrl_r <= EXT_CTRL_RST;
    end else begin
      if (wr_sel_w)
        clk_sel_r  <= sfr_req_in.wdata & CLK_SEL_WMASK;
      if (wr_lf_w)
        lf_ctrl_r  <= sfr_req_in.wdata & LF_CTRL_WMASK;
      if (wr_ext_w)
        ext_ctrl_r <= sfr_req_in.wdata & EXT_CTRL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  wire       lf_en_w   = lf_ctrl_r[LF_EN_BIT];
  wire [3:0] lf_trim_w = lf_ctrl_r[LF_TRIM_LSB +: 4];
  wire [1:0] lf_div_w  = lf_ctrl_r[LF_DIV_LSB +: 2];
  wire [1:0] odiv_w    = clk_sel_r[SEL_ODIV_LSB +: 2];
  wire [2:0] src_w     = clk_sel_r[SEL_SRC_LSB +: 3];
  wire [2:0] xmode_w   = ext_ctrl_r[EXT_MODE_LSB +: 3];
  wire [2:0] external_freq_control_w    = ext_ctrl_r[EXT_FCN_LSB +: 3];
  wire       x_off_w   = (xmode_w[2:1] == XMODE_OFF_HI);
  wire       x_xtal_w  = (xmode_w[2:1] == XMODE_XTAL_HI);
  // CMOS and crystal modes with the extra halving stage
  wire       x_half_w  = (xmode_w == XMODE_CMOS_DIV) || (xmode_w == 3'h7);

  wire lf_ready_w = lf_en_w && sync_r[SY_LFOK];
  wire x_valid_w  = x_xtal_w && sync_r[SY_XOK];

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [7:0] rdata_r;
  wire  [7:0] rd_lf_w  = {lf_en_w, lf_ready_w, lf_trim_w, lf_div_w};
  wire  [7:0] rd_ext_w = {x_valid_w, xmode_w, 1'b0, external_freq_control_w};
  wire  [7:0] rd_sel_w = {2'b00, odiv_w, 1'b0, src_w};
  wire  [7:0] rd_nxt   =
    (sfr_req_in.addr == ADDR_CLK_SEL)  ? rd_sel_w :
    (sfr_req_in.addr == ADDR_LF_CTRL)  ? rd_lf_w  :
    (sfr_req_in.addr == ADDR_EXT_CTRL) ? rd_ext_w : RD_UNMAPPED;

  always_ff @(posedge clock_in) begin
    if (srst_in)
      rdata_r <= RD_UNMAPPED;
    else
      rdata_r <= rd_nxt;
  end

  // ---------------------------------------------------------------
  // Oscillator sources and dividers
  // ---------------------------------------------------------------
  logic hf_lvl_w;
  logic lf_lvl_w;
  logic ext_half_r;
  logic ext_lvl_r;
  logic ext_prev_r;
  logic pll_lock_r;

  // Gating here is what stops the slow oscillator when disabled
  wire lf_run_w = lf_en_w && sync_r[SY_LF];

  scss_div u_lf_div (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .level_in  (lf_run_w),
    .shift_in  (~lf_div_w),
    .level_out (lf_lvl_w)
  );

  scss_div u_hf_div (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .level_in  (sync_r[SY_HF]),
    .shift_in  (~high_freq_divider_in),
    .level_out (hf_lvl_w)
  );

  // External clock runs whatever source drives the system clock
  wire ext_rise_w = sync_r[SY_EXT] && !ext_prev_r;
  wire ext_nxt    = x_off_w  ? 1'b0 :
                    x_half_w ? (ext_half_r ^ ext_rise_w) :
                               sync_r[SY_EXT];

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ext_half_r <= 1'b0;
      ext_prev_r <= 1'b0;
      ext_lvl_r  <= 1'b0;
      pll_lock_r <= 1'b0;
    end else begin
      ext_prev_r <= sync_r[SY_EXT];
      ext_half_r <= ext_half_r ^ ext_rise_w;
      ext_lvl_r  <= ext_nxt;
      pll_lock_r <= sync_r[SY_LOCK];
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free source switch
  // ---------------------------------------------------------------
  scss_src_e  cur_r;
  scss_src_e  req_w;
  logic       req_ok_w;
  logic       sys_r;
  wire  [3:0] src_lvl_w = {sync_r[SY_PLL], lf_lvl_w, ext_lvl_r, hf_lvl_w};

  // Reserved codes keep the present source rather than stop the core
  always_comb begin
    req_ok_w = 1'b1;
    req_w    = cur_r;
    unique case (src_w)
      SRC_CODE_HF:  req_w = SRC_HF;
      SRC_CODE_EXT: req_w = SRC_EXT;
      SRC_CODE_LF:  req_w = SRC_LF;
      SRC_CODE_PLL: req_w = SRC_PLL;
      default:      req_ok_w = 1'b0;
    endcase
  end

  // Handover only while both clocks are low, so no pulse is shortened;
  // a new source stopped low is taken once the old one is low, one stopped high holds the old one (software selects settled ones)
  wire switch_w = req_ok_w && (req_w != cur_r) &&
                  !src_lvl_w[cur_r] && !src_lvl_w[req_w];
  wire scss_src_e cur_nxt = switch_w ? req_w : cur_r;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cur_r <= SRC_HF;
      sys_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      sys_r <= src_lvl_w[cur_r];
    end
  end

  scss_div u_out_div (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .level_in  (sys_r),
    .shift_in  (odiv_w),
    .level_out (clock_pin_out)
  );

  // ---------------------------------------------------------------
  // Calibration capture
  // ---------------------------------------------------------------
  logic      lf_prev_r;
  scss_cap_s t2_r;
  scss_cap_s t3_r;
  wire lf_fall_w = lf_prev_r && !lf_lvl_w;
  wire lf_rise_w = !lf_prev_r && lf_lvl_w;
  wire t2_hit_w  = t2_capture_mode_in && lf_fall_w;
  wire t3_hit_w  = t3_capture_mode_in && lf_rise_w;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lf_prev_r <= 1'b0;
      t2_r      <= '0;
      t3_r      <= '0;
    end else begin
      lf_prev_r   <= lf_lvl_w;
      t2_r.pulse  <= t2_hit_w;
      t3_r.pulse  <= t3_hit_w;
      if (t2_hit_w)
        t2_r.value <= t2_count_in;
      if (t3_hit_w)
        t3_r.value <= t3_count_in;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic claim1_r;
  logic claim2_r;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      claim1_r <= 1'b0;
      claim2_r <= 1'b0;
    end else begin
      claim1_r <= x_xtal_w;
      claim2_r <= !x_off_w;
    end
  end

  assign sfr_rdata_out             = rdata_r;
  assign t2_cap_out                = t2_r;
  assign t3_cap_out                = t3_r;
  assign low_freq_osc_enable_out   = lf_en_w;
  assign low_freq_fine_tune_out    = lf_trim_w;
  assign external_osc_mode_out     = xmode_w;
  assign external_freq_control_out = external_freq_control_w;
  assign pll_lock_flag_out         = pll_lock_r;
  assign system_clock_out          = sys_r;
  assign ext_timer_clock_out       = ext_lvl_r;
  assign active_source_out         = cur_r;
  assign crystal_pin_in_claim_out  = claim1_r;
  assign crystal_pin_out_claim_out = claim2_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Disabled for two samples: the slow divider must see no further edge
  property p_lf_gate;
    @(posedge clock_in) disable iff (srst_in)
      !lf_en_w && !$past(lf_en_w) |=> $stable(u_lf_div.cnt_r);
  endproperty
  a_lf_gate: assert property (p_lf_gate)
    else $error("slow oscillator ran while disabled");

  property p_lf_ready;
    @(posedge clock_in) disable iff (srst_in)
      $past(sfr_req_in.addr) == ADDR_LF_CTRL && sfr_rdata_out[LF_RDY_BIT]
        |-> $past(lf_en_w);
  endproperty
  a_lf_ready: assert property (p_lf_ready)
    else $error("ready bit read one with oscillator disabled");

  property p_xvalid;
    @(posedge clock_in) disable iff (srst_in)
      $past(sfr_req_in.addr) == ADDR_EXT_CTRL && sfr_rdata_out[EXT_VALID_BIT]
        |-> $past(x_xtal_w) && $past(sync_r[SY_XOK]);
  endproperty
  a_xvalid: assert property (p_xvalid)
    else $error("crystal valid read one outside crystal mode");

  property p_rsv_zero;
    @(posedge clock_in) disable iff (srst_in)
      $past(sfr_req_in.addr) == ADDR_EXT_CTRL |-> !sfr_rdata_out[3]
        && sfr_rdata_out[6:4] == $past(xmode_w);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("external control bit 3 read nonzero");

  property p_sel_reset;
    @(posedge clock_in)
      srst_in |=> clk_sel_r == CLK_SEL_RST && ext_ctrl_r == EXT_CTRL_RST;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("select or external register not cleared by reset");

  property p_switch_low;
    @(posedge clock_in) disable iff (srst_in)
      cur_r != $past(cur_r) |-> !$past(src_lvl_w[cur_r])
        && ($past(src_lvl_w) & (4'h1 << cur_r)) == 4'h0;
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("source changed while old or new clock high");

  property p_cap2;
    @(posedge clock_in) disable iff (srst_in)
      t2_cap_out.pulse |-> t2_cap_out.value == $past(t2_count_in)
        && $past(lf_prev_r) && !$past(lf_lvl_w);
  endproperty
  a_cap2: assert property (p_cap2)
    else $error("timer two capture wrong value or edge");

  property p_cap3;
    @(posedge clock_in) disable iff (srst_in)
      t3_cap_out.pulse |-> t3_cap_out.value == $past(t3_count_in)
        && !$past(lf_prev_r) && $past(lf_lvl_w);
  endproperty
  a_cap3: assert property (p_cap3)
    else $error("timer three capture wrong value or edge");

  property p_claim;
    @(posedge clock_in) disable iff (srst_in)
      crystal_pin_in_claim_out |-> crystal_pin_out_claim_out
        && $past(xmode_w[2:1]) == XMODE_XTAL_HI;
  endproperty
  a_claim: assert property (p_claim)
    else $error("first crystal pin claimed outside crystal mode");

endmodule
`default_nettype wire

// ---- testbench/scss_xosc_model.sv ----
// Behavioural external oscillator seen on the second crystal pin
`timescale 1ns/1ps
`default_nettype none
module scss_xosc_model #(
  parameter int HALF_NS   = 100,
  parameter int SETTLE_NS = 50000
) (
  // Mode field of the external control register
  input  wire logic [2:0] mode_in,
  // Oscillator level and amplitude status
  output logic            osc_out,
  output logic            stable_out
);
  // ---------------------------------------------------------------
  // Oscillation
  // ---------------------------------------------------------------
  // The circuit is unpowered when off, so the level stops low
  // Only a crystal that stayed in crystal mode for the settle span is stable
  time chg_t = 0;
  initial begin
    osc_out = 1'b0;
    stable_out = 1'b0;
    forever begin
      #(HALF_NS);
      osc_out = (mode_in[2:1] != 2'h0) ? ~osc_out : 1'b0;
      stable_out = (mode_in[2:1] == 2'h3) && ($time - chg_t >= SETTLE_NS);
    end
  end
  // ---------------------------------------------------------------
  // Amplitude detection
  // ---------------------------------------------------------------
  // Any mode change restarts the settle span
  always @(mode_in) chg_t = $time;
endmodule
`default_nettype wire

// ---- testbench/system_clock_source_select_bench.sv ----
// Self-checking bench of the clock source selector
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_bench;
  import scss_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clock_in, srst_in, hf_osc_in, lf_osc_in, ext_osc_in, pll_clk_in;
  logic lf_settled_in, xtal_stable_in, pll_locked_in, t2_capture_mode_in;
  logic t3_capture_mode_in, low_freq_osc_enable_out, pll_lock_flag_out;
  logic system_clock_out, clock_pin_out, ext_timer_clock_out;
  logic crystal_pin_in_claim_out, crystal_pin_out_claim_out;
  logic [1:0]    high_freq_divider_in;
  logic [3:0]    trim_cal_in, low_freq_fine_tune_out, mon, mon_q;
  logic [2:0]    external_osc_mode_out, external_freq_control_out;
  logic [7:0]    sfr_rdata_out, d, lfs, exs;
  logic [15:0]   t2_count_in, t3_count_in;
  scss_sfr_req_s sfr_req_in;
  scss_cap_s     t2_cap_out, t3_cap_out;
  scss_src_e     active_source_out;
  int            error_cnt, cmp_count, seed, cyc, gap, npul, i, k, hic;
  int            last[4], per[4];
  localparam logic [7:0] RA [4] = '{ADDR_CLK_SEL, ADDR_LF_CTRL,
                                    ADDR_EXT_CTRL, 8'h90};
  localparam logic [7:0] WM [4] = '{8'h30, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RM [4] = '{8'h37, 8'hbf, 8'h77, 8'h00};
  localparam logic [2:0] SC [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  localparam scss_src_e  SE [4] = '{SRC_EXT, SRC_LF, SRC_PLL, SRC_PLL};
  localparam int         PE [4] = '{8, 8, 4, 4};
  // High cycles of the system clock in any eight consecutive cycles
  localparam int         HI [4] = '{4, 3, 4, 4};

  scss_top dut_u (.clock_in, .srst_in, .sfr_req_in, .sfr_rdata_out,
    .high_freq_divider_in, .trim_cal_in, .hf_osc_in, .lf_osc_in,
    .ext_osc_in, .pll_clk_in, .lf_settled_in, .xtal_stable_in,
    .pll_locked_in, .t2_capture_mode_in, .t3_capture_mode_in,
    .t2_count_in, .t3_count_in, .t2_cap_out, .t3_cap_out,
    .low_freq_osc_enable_out, .low_freq_fine_tune_out,
    .external_osc_mode_out, .external_freq_control_out,
    .pll_lock_flag_out, .system_clock_out, .clock_pin_out,
    .ext_timer_clock_out, .active_source_out, .crystal_pin_in_claim_out,
    .crystal_pin_out_claim_out);
  scss_xosc_model xosc_u (.mode_in(external_osc_mode_out),
    .osc_out(ext_osc_in), .stable_out(xtal_stable_in));

  // ---------------------------------------------------------------
  // Clocks and free-running stimulus
  // ---------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // Uneven duty lets the rising and falling captures be told apart
  initial begin
    forever begin
      #125 lf_osc_in = 1'b1;
      #75 lf_osc_in = 1'b0;
    end
  end
  always #75 hf_osc_in = ~hf_osc_in;
  always #50 pll_clk_in = ~pll_clk_in;
  always @(posedge clock_in) begin
    #1;
    t2_count_in = t2_count_in + 16'h1;
    t3_count_in = ~t2_count_in;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] div_per(input int base, input int sh);
    return 16'(base << sh);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_req_in = '{a, 1'b1, v};
    step(1);
    sfr_req_in.wr = 1'b0;
    step(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    sfr_req_in = '{a, 1'b0, 8'h00};
    step(1);
    chk({8'h00, sfr_rdata_out}, {8'h00, exp});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Period of each watched signal in cycles, and capture values
  assign mon = {ext_timer_clock_out, t2_cap_out.pulse, t3_cap_out.pulse,
                clock_pin_out};
  always @(negedge clock_in) begin
    cyc++;
    for (int j = 0; j < 4; j++) begin
      if (mon[j] && !mon_q[j]) begin
        per[j] = cyc - last[j];
        last[j] = cyc;
      end
    end
    if (t2_cap_out.pulse === 1'b1) begin
      npul++;
      gap = cyc - last[1];
      chk(t2_cap_out.value, t2_count_in - 16'h1);
    end
    if (t3_cap_out.pulse === 1'b1) begin
      npul++;
      chk(t3_cap_out.value, ~(t2_count_in - 16'h1));
    end
    mon_q = mon;
  end

  initial begin
    #(60000 * 25);
    error_cnt++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    seed = 53;
    {srst_in, hf_osc_in, lf_osc_in, pll_clk_in, lf_settled_in} = 5'h10;
    {pll_locked_in, t2_capture_mode_in, t3_capture_mode_in} = 3'h0;
    sfr_req_in = '0;
    high_freq_divider_in = 2'h3;
    trim_cal_in = 4'($random(seed));
    t2_count_in = 16'($random(seed));
    t3_count_in = 16'h0;
    mon_q = 4'h0;
    step(20);
    srst_in = 1'b0;
    rc(ADDR_CLK_SEL, 8'h00);
    rc(ADDR_LF_CTRL, {2'h0, trim_cal_in, 2'h0});
    rc(ADDR_EXT_CTRL, 8'h00);
    chk({15'h0, pll_lock_flag_out}, 16'h0);
    lfs = {2'h0, trim_cal_in, 2'h0};
    exs = 8'h00;
    for (i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      k = i % 4;
      wr(RA[k], d & WM[k]);
      rc(RA[k], d & WM[k] & RM[k]);
      if (k == 1) lfs = d;
      if (k == 2) exs = d;
      chk({low_freq_osc_enable_out, low_freq_fine_tune_out,
           external_osc_mode_out, external_freq_control_out},
          {lfs[7], lfs[5:2], exs[6:4], exs[2:0]});
      chk({crystal_pin_in_claim_out, crystal_pin_out_claim_out},
          {exs[6:5] == 2'h3, exs[6:5] != 2'h0});
    end
    $display("register test done");
    lf_settled_in = 1'b1;
    wr(ADDR_LF_CTRL, 8'h83);
    step(5);
    rc(ADDR_LF_CTRL, 8'hc3);
    {t2_capture_mode_in, t3_capture_mode_in} = 2'h3;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_LF_CTRL, 8'h80 | 8'(i));
      step(200);
      chk(16'(per[1]), div_per(8, 3 - i));
      chk(16'(per[2]), div_per(8, 3 - i));
    end
    chk(16'(gap), 16'h3);
    {t2_capture_mode_in, t3_capture_mode_in} = 2'h0;
    step(2);
    npul = 0;
    step(100);
    chk(16'(npul), 16'h0);
    // A disabled slow oscillator must give no edge to capture
    wr(ADDR_LF_CTRL, 8'h03);
    step(2);
    {t2_capture_mode_in, t3_capture_mode_in} = 2'h3;
    npul = 0;
    step(100);
    chk(16'(npul), 16'h0);
    $display("capture test done");
    for (i = 0; i < 4; i++) begin
      k = $random(seed) & 3;
      high_freq_divider_in = 2'(i);
      wr(ADDR_CLK_SEL, 8'(k << 4));
      step(1200);
      chk(16'(per[0]), div_per(6, 3 - i + k));
    end
    wr(ADDR_EXT_CTRL, 8'h20);
    wr(ADDR_LF_CTRL, 8'h83);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_CLK_SEL, {5'h0, SC[i]});
      step(300);
      chk(16'(active_source_out), 16'(SE[i]));
      chk(16'(per[0]), 16'(PE[i]));
      hic = 0;
      repeat (8) begin
        step(1);
        hic += system_clock_out;
      end
      chk(16'(hic), 16'(HI[i]));
    end
    chk(16'(per[3]), 16'h8);
    wr(ADDR_EXT_CTRL, 8'h30);
    step(100);
    chk(16'(per[3]), 16'h10);
    $display("source test done");
    wr(ADDR_EXT_CTRL, 8'h67);
    rc(ADDR_EXT_CTRL, 8'h67);
    step(40000);
    rc(ADDR_EXT_CTRL, 8'he7);
    chk({13'h0, external_freq_control_out}, 16'h7);
    pll_locked_in = 1'b1;
    step(4);
    chk({15'h0, pll_lock_flag_out}, 16'h1);
    $display("status test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
